// [logic/mfepc_fifo.sv]
`timescale 1ns/1ps
module mfepc_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 4
) (
  input  wire logic             SYS_CLK,
  input  wire logic             SYS_RST,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } mfepc_fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  mfepc_fifo_st_t   st_reg;
  mfepc_fifo_st_t   st_next;
  logic             push;
  logic             pop;

  // Handshakes are combinational so a full buffer stalls the source at once.
  assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[st_reg.rd_ptr];

  // Pointer and occupancy update.
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Storage holds no control state, so it needs no reset.
  always_ff @(posedge SYS_CLK) begin
    if (push) begin
      mem[st_reg.wr_ptr] <= in_data;
    end
  end

endmodule : mfepc_fifo

// [logic/mfepc_top.sv]
// Our own choice: strobed register access.
`timescale 1ns/1ps
module mfepc_top (
  input  wire logic                              SYS_CLK,
  input  wire logic                              SYS_RST,
  input  wire logic [15:0]                       ADDR,
  input  wire logic [7:0]                        WDATA,
  input  wire logic                              WR_STB,
  input  wire logic                              RD_STB,
  output logic      [7:0]                        RDATA,
  input  wire logic                              IN_VALID,
  input  wire mfepc_pkg::mfepc_trio_t            IN_DATA,
  output logic                                   CONV_ON_V,
  output logic                                   CONV_ON_B,
  output logic                                   CONV_ON_A,
  output logic                                   VOLT_X2,
  output logic      [5:0]                        GAIN_B,
  output logic      [5:0]                        GAIN_A,
  output logic      [2:0]                        RATE_MULT,
  output logic                                   PHC_TICK,
  output logic                                   OUT_VALID,
  input  wire logic                              OUT_READY,
  output mfepc_pkg::mfepc_path_t                 OUT_DATA
);

  // ****************************************************************
  // Types, state and helpers
  // ****************************************************************
  localparam int SW = mfepc_pkg::MFE_SAMPLE_W;
  localparam int DP = mfepc_pkg::MFE_DEPTH;

  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] conv;
    logic [7:0] clock;
    logic [7:0] path;
    logic [7:0] dly1;
    logic [7:0] dly2;
    logic [7:0] dlyext;
    logic [7:0] rdata;
    logic [7:0] wptr;
    logic [7:0] tick_cnt;
    logic       tick;
    logic       out_vld;
    mfepc_pkg::mfepc_path_t out;
  } mfepc_st_t;

  mfepc_st_t   st_reg;
  mfepc_st_t   st_next;
  logic [SW-1:0] hist_v [DP];
  logic [SW-1:0] hist_1 [DP];
  logic [SW-1:0] hist_2 [DP];
  logic [SW-1:0] snap_v;
  logic [SW-1:0] snap_1;
  logic [SW-1:0] snap_2;
  logic          fifo_in_ready;

  // Gain code to linear factor; codes 1xx saturate at x32.
  function automatic logic [5:0] gain_factor(input logic [2:0] code,
                                             input logic allow16);
    logic [5:0] g;
    g = 6'h20;
    unique case (code)
      3'h0: g = 6'h01;
      3'h1: g = 6'h04;
      3'h2: g = 6'h08;
      3'h3: g = allow16 ? 6'h10 : 6'h01;
      default: g = 6'h20;
    endcase
    return g;
  endfunction : gain_factor

  // Force bit 20 to repeat bit 21 so both carry the sign.
  function automatic logic [SW-1:0] sign_fix(input logic [SW-1:0] s);
    return {s[SW-1], s[SW-1], s[SW-3:0]};
  endfunction : sign_fix

  // Eight-bit magnitude from six register bits plus two extension bits.
  function automatic logic [7:0] magnitude(input logic [7:0] r,
                                           input logic [1:0] ext);
    return {ext, r[5:0]};
  endfunction : magnitude

  // ****************************************************************
  // Register access and stream processing
  // ****************************************************************
  logic [SW-1:0] cur1;
  logic [SW-1:0] cur2;
  logic [SW-1:0] vin;
  logic [7:0]    mag1;
  logic [7:0]    mag2;
  logic          neg1;
  logic          neg2;
  logic          phc_on;
  logic [7:0]    tick_top;
  logic          advance;

  always_comb begin
    vin  = IN_VALID ? sign_fix(IN_DATA.volt) : '0;
    // Swap crosses the two current streams ahead of compensation.
    cur1 = st_reg.path[mfepc_pkg::MFE_BIT_SWAP] ? IN_DATA.cur_b
                                                : IN_DATA.cur_a;
    cur2 = st_reg.path[mfepc_pkg::MFE_BIT_SWAP] ? IN_DATA.cur_a
                                                : IN_DATA.cur_b;
    cur1 = IN_VALID ? sign_fix(cur1) : '0;
    cur2 = IN_VALID ? sign_fix(cur2) : '0;
    phc_on = st_reg.path[mfepc_pkg::MFE_BIT_PHC_ON];
    mag1 = magnitude(st_reg.dly1, st_reg.dlyext[1:0]);
    mag2 = magnitude(st_reg.dly2, st_reg.dlyext[3:2]);
    neg1 = st_reg.dly1[mfepc_pkg::MFE_BIT_SIGN];
    neg2 = st_reg.dly2[mfepc_pkg::MFE_BIT_SIGN];
    // Rate divider follows the clock multiplier field.
    unique case (st_reg.clock[mfepc_pkg::MFE_CLK_LSB +: 2])
      2'h1: tick_top = 8'(mfepc_pkg::MFE_TICK_X2 - 1);
      2'h2: tick_top = 8'(mfepc_pkg::MFE_TICK_X4 - 1);
      default: tick_top = 8'(mfepc_pkg::MFE_TICK_X1 - 1);
    endcase
    advance = st_reg.tick && fifo_in_ready;
  end

  // Reads of the history taken at the programmed depth.
  assign snap_v = hist_v[8'(st_reg.wptr - (neg1 ? mag1 : mag2))];
  assign snap_1 = hist_1[8'(st_reg.wptr - mag1)];
  assign snap_2 = hist_2[8'(st_reg.wptr - mag2)];

  // Next-state logic for registers, the rate tick and the output word.
  always_comb begin
    st_next = st_reg;
    st_next.out_vld = 1'b0;
    // Tick runs at the selected sampling rate.
    if (st_reg.tick_cnt >= tick_top) begin
      st_next.tick_cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 8'h01;
      st_next.tick = 1'b0;
    end
    if (advance) begin
      st_next.wptr = st_reg.wptr + 8'h01;
      st_next.out_vld = 1'b1;
      if (!phc_on) begin
        // Bypass gives all three paths the same single stage.
        st_next.out.volt = vin;
        st_next.out.i1 = cur1;
        st_next.out.i2 = cur2;
      end else begin
        // Positive sign delays current, negative delays voltage.
        st_next.out.i1 = neg1 ? cur1 : (mag1 == 8'h00 ? cur1 : snap_1);
        st_next.out.i2 = neg2 ? cur2 : (mag2 == 8'h00 ? cur2 : snap_2);
        // One voltage stream serves both pairs; I1's sign takes it first.
        st_next.out.volt = (neg1 || neg2) ? snap_v : vin;
        if (neg1 || neg2) begin
          if ((neg1 ? mag1 : mag2) == 8'h00) begin
            st_next.out.volt = vin;
          end
        end
      end
    end
    if (WR_STB) begin
      unique case (ADDR)
        mfepc_pkg::MFE_ADDR_GAIN:   st_next.gain = WDATA;
        mfepc_pkg::MFE_ADDR_CONV:   st_next.conv = WDATA;
        mfepc_pkg::MFE_ADDR_CLOCK:  st_next.clock = WDATA;
        mfepc_pkg::MFE_ADDR_PATH:   st_next.path = WDATA;
        mfepc_pkg::MFE_ADDR_DLY1:   st_next.dly1 = WDATA;
        mfepc_pkg::MFE_ADDR_DLY2:   st_next.dly2 = WDATA;
        mfepc_pkg::MFE_ADDR_DLYEXT: st_next.dlyext = WDATA;
        default: st_next.gain = st_reg.gain;
      endcase
    end
    st_next.rdata = 8'h00;
    if (RD_STB) begin
      unique case (ADDR)
        mfepc_pkg::MFE_ADDR_GAIN:   st_next.rdata = st_reg.gain;
        mfepc_pkg::MFE_ADDR_CONV:   st_next.rdata = st_reg.conv;
        mfepc_pkg::MFE_ADDR_CLOCK:  st_next.rdata = st_reg.clock;
        mfepc_pkg::MFE_ADDR_PATH:   st_next.rdata = st_reg.path;
        mfepc_pkg::MFE_ADDR_DLY1:   st_next.rdata = st_reg.dly1;
        mfepc_pkg::MFE_ADDR_DLY2:   st_next.rdata = st_reg.dly2;
        mfepc_pkg::MFE_ADDR_DLYEXT: st_next.rdata = st_reg.dlyext;
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  // State register; every control field resets to zero.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Histories advance only on accepted ticks, so a stall freezes them.
  always_ff @(posedge SYS_CLK) begin
    if (advance) begin
      hist_v[st_reg.wptr] <= vin;
      hist_1[st_reg.wptr] <= cur1;
      hist_2[st_reg.wptr] <= cur2;
    end
  end

  // ****************************************************************
  // Output buffer and pins
  // ****************************************************************
  mfepc_fifo #(
    .WIDTH($bits(mfepc_pkg::mfepc_path_t)),
    .DEPTH(mfepc_pkg::MFE_FIFO_DEPTH)
  ) u_fifo (
    .SYS_CLK  (SYS_CLK),
    .SYS_RST  (SYS_RST),
    .in_valid (st_reg.out_vld),
    .in_ready (fifo_in_ready),
    .in_data  (st_reg.out),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY),
    .out_data (OUT_DATA)
  );

  // Converter enables and gain decode come straight from registers.
  assign CONV_ON_V = st_reg.conv[mfepc_pkg::MFE_BIT_CONV_V];
  assign CONV_ON_B = st_reg.conv[mfepc_pkg::MFE_BIT_CONV_B];
  assign CONV_ON_A = st_reg.conv[mfepc_pkg::MFE_BIT_CONV_A];
  assign VOLT_X2   = st_reg.gain[mfepc_pkg::MFE_BIT_VGAIN];
  assign GAIN_B    = gain_factor(st_reg.gain[5:3], 1'b0);
  assign GAIN_A    = gain_factor(st_reg.gain[2:0], 1'b1);
  assign RATE_MULT = (st_reg.clock[3:2] == 2'h1) ? 3'h2 :
                     (st_reg.clock[3:2] == 2'h2) ? 3'h4 : 3'h1;
  assign PHC_TICK  = advance;
  assign RDATA     = st_reg.rdata;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_conv_enable: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $past(WR_STB) && $past(ADDR) == mfepc_pkg::MFE_ADDR_CONV
    |-> CONV_ON_V == $past(WDATA[2]) && CONV_ON_A == $past(WDATA[0]))
    else $error("converter enable mismatch");
  a_gain_b_map: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    st_reg.gain[5] |-> GAIN_B == 6'h20)
    else $error("gain B not x32");
  a_gain_a_x16: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    st_reg.gain[2:0] == 3'h3 |-> GAIN_A == 6'h10)
    else $error("gain A code 3 not x16");
  a_sign_dup: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    st_reg.out_vld |-> st_reg.out.i1[21] == st_reg.out.i1[20])
    else $error("sign bits differ");
  a_swap_route: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    advance && !phc_on && IN_VALID && st_reg.path[5]
    |=> st_reg.out.i1 == sign_fix($past(IN_DATA.cur_b)))
    else $error("swap routing wrong");
  a_bypass_same: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    advance && !phc_on && IN_VALID
    |=> st_reg.out.volt == sign_fix($past(IN_DATA.volt)))
    else $error("bypass latency wrong");
  // Cycles since the last rate tick, and whether the clock register moved since.
  // A counter stands in for a long repetition, which the tools unroll.
  logic [7:0] gap_cnt;
  logic       clk_moved;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      gap_cnt   <= 8'h00;
      clk_moved <= 1'b1;
    end else if (st_reg.tick) begin
      gap_cnt   <= 8'h01;
      clk_moved <= (st_next.clock != st_reg.clock);
    end else begin
      gap_cnt   <= gap_cnt + 8'h01;
      clk_moved <= clk_moved || (st_next.clock != st_reg.clock);
    end
  end

  a_tick_period: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    st_reg.tick && !clk_moved |-> gap_cnt == tick_top + 8'h01)
    else $error("tick rate wrong");
  a_delay_ptr: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    advance |=> st_reg.wptr == $past(st_reg.wptr) + 8'h01)
    else $error("chain did not advance");
  a_volt_delay: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    advance && phc_on && !neg1 && !neg2 |=> st_reg.out.volt == $past(vin))
    else $error("voltage delayed on positive sign");

  c_phc_used: cover property (@(posedge SYS_CLK) advance && phc_on);
  c_swap_used: cover property (@(posedge SYS_CLK) advance && st_reg.path[5]);
  c_fifo_full: cover property (@(posedge SYS_CLK) !fifo_in_ready);
  c_neg_sign: cover property (@(posedge SYS_CLK) advance && phc_on && neg1);

endmodule : mfepc_top

// [shared/mfepc_pkg.sv]
package mfepc_pkg;

  localparam logic [15:0] MFE_ADDR_GAIN   = 16'h2858;
  localparam logic [15:0] MFE_ADDR_CONV   = 16'h2864;
  localparam logic [15:0] MFE_ADDR_CLOCK  = 16'h2867;
  localparam logic [15:0] MFE_ADDR_PATH   = 16'h2878;
  localparam logic [15:0] MFE_ADDR_DLY1   = 16'h287b;
  localparam logic [15:0] MFE_ADDR_DLY2   = 16'h287c;
  localparam logic [15:0] MFE_ADDR_DLYEXT = 16'h287f;

  localparam logic [7:0] MFE_RST_BYTE = 8'h00;

  localparam int MFE_BIT_VGAIN   = 6;
  localparam int MFE_BIT_CONV_V  = 2;
  localparam int MFE_BIT_CONV_B  = 1;
  localparam int MFE_BIT_CONV_A  = 0;
  localparam int MFE_BIT_PHC_ON  = 6;
  localparam int MFE_BIT_SWAP    = 5;
  localparam int MFE_BIT_SIGN    = 7;
  localparam int MFE_CLK_LSB     = 2;

  localparam int MFE_SAMPLE_W = 22;
  localparam int MFE_MAG_W    = 8;
  localparam int MFE_DEPTH    = 256;
  localparam int MFE_FIFO_DEPTH = 4;

  localparam longint MFE_SYS_HZ  = 50000000;
  localparam longint MFE_BASE_HZ = 819200;
  localparam int MFE_TICK_X1 = int'(MFE_SYS_HZ / MFE_BASE_HZ);
  localparam int MFE_TICK_X2 = int'(MFE_SYS_HZ / (2 * MFE_BASE_HZ));
  localparam int MFE_TICK_X4 = int'(MFE_SYS_HZ / (4 * MFE_BASE_HZ));

  typedef struct packed {
    logic [MFE_SAMPLE_W-1:0] volt;
    logic [MFE_SAMPLE_W-1:0] cur_a;
    logic [MFE_SAMPLE_W-1:0] cur_b;
  } mfepc_trio_t;

  typedef struct packed {
    logic [MFE_SAMPLE_W-1:0] volt;
    logic [MFE_SAMPLE_W-1:0] i1;
    logic [MFE_SAMPLE_W-1:0] i2;
  } mfepc_path_t;

endpackage : mfepc_pkg

// [tb/mfepc_sensor_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Sensor side stand-in: one fresh sample set per chain advance.
// ****************************************************************
module mfepc_sensor_model (
  input  wire logic              SYS_CLK,
  input  wire logic              SYS_RST,
  input  wire logic              PHC_TICK,
  input  wire logic              sens_on,
  output logic                   IN_VALID,
  output mfepc_pkg::mfepc_trio_t IN_DATA
);
  logic [15:0] n_reg;

  // The index moves only when the chain takes a set, so lost or doubled
  // samples show up as gaps in the index seen at the far end.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      n_reg <= 16'h0000;
    end else if (PHC_TICK && sens_on) begin
      n_reg <= n_reg + 16'h0001;
    end
  end

  // Each stream carries a tag and the index; voltage sets bit 21 alone.
  // Released data is inverted, so a stale set never looks like fresh data.
  always_comb begin
    IN_VALID      = sens_on;
    IN_DATA.volt  = {2'h2, 4'h3, n_reg};
    IN_DATA.cur_a = {2'h0, 4'h1, n_reg};
    IN_DATA.cur_b = {2'h0, 4'h2, n_reg};
    if (!sens_on) begin
      IN_DATA = ~IN_DATA;
    end
  end
endmodule : mfepc_sensor_model

// [tb/mfepc_top_tb.sv]
`timescale 1ns/1ps
module mfepc_top_tb;
  logic                   SYS_CLK = 1'b0;
  logic                   SYS_RST;
  logic [15:0]            ADDR;
  logic [7:0]             WDATA;
  logic                   WR_STB;
  logic                   RD_STB;
  logic [7:0]             RDATA;
  logic                   IN_VALID;
  mfepc_pkg::mfepc_trio_t IN_DATA;
  logic                   CONV_ON_V;
  logic                   CONV_ON_B;
  logic                   CONV_ON_A;
  logic                   VOLT_X2;
  logic [5:0]             GAIN_B;
  logic [5:0]             GAIN_A;
  logic [2:0]             RATE_MULT;
  logic                   PHC_TICK;
  logic                   OUT_VALID;
  logic                   OUT_READY;
  mfepc_pkg::mfepc_path_t OUT_DATA;
  logic                   sens_on;
  int                     num_errors = 0;
  int                     check_count = 0;
  int                     c;
  int                     g;
  int                     tk;
  mfepc_pkg::mfepc_path_t w;
  mfepc_pkg::mfepc_path_t got_q [$];
  logic [15:0]            regs [7] = '{16'h2858, 16'h2864, 16'h2867,
                                       16'h2878, 16'h287b, 16'h287c,
                                       16'h287f};
  logic [5:0]             gb [8] = '{1, 4, 8, 1, 32, 32, 32, 32};
  logic [5:0]             ga [8] = '{1, 4, 8, 16, 32, 32, 32, 32};
  logic [2:0]             rm [4] = '{1, 2, 4, 1};
  int                     tg [4] = '{mfepc_pkg::MFE_TICK_X1,
                                     mfepc_pkg::MFE_TICK_X2,
                                     mfepc_pkg::MFE_TICK_X4,
                                     mfepc_pkg::MFE_TICK_X1};

  // Free running 50 MHz clock.
  always #10 SYS_CLK = ~SYS_CLK;

  mfepc_top i_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
    .IN_VALID(IN_VALID), .IN_DATA(IN_DATA), .CONV_ON_V(CONV_ON_V),
    .CONV_ON_B(CONV_ON_B), .CONV_ON_A(CONV_ON_A), .VOLT_X2(VOLT_X2),
    .GAIN_B(GAIN_B), .GAIN_A(GAIN_A), .RATE_MULT(RATE_MULT),
    .PHC_TICK(PHC_TICK), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
    .OUT_DATA(OUT_DATA));

  mfepc_sensor_model i_sensor (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .PHC_TICK(PHC_TICK), .sens_on(sens_on), .IN_VALID(IN_VALID),
    .IN_DATA(IN_DATA));

  // Every word handed over at an edge is kept for later inspection.
  always @(posedge SYS_CLK) begin
    if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
      got_q.push_back(OUT_DATA);
    end
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, g_v);
    check_count++;
    if (e !== g_v) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g_v);
    end
  endtask : chk

  // A bound that runs out counts as a mismatch and ends the run.
  task automatic hang(input string nm);
    num_errors++;
    $display("ERROR %s expected done seen timeout", nm);
    conclude();
  endtask : hang

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR   <= a;
    WDATA  <= d;
    WR_STB <= 1'b1;
    @(posedge SYS_CLK);
    WR_STB <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [15:0] a, input logic [7:0] e,
                    input string nm);
    @(posedge SYS_CLK);
    ADDR   <= a;
    RD_STB <= 1'b1;
    @(posedge SYS_CLK);
    RD_STB <= 1'b0;
    #1;
    chk(nm, 32'(e), 32'(RDATA));
  endtask : rd

  // Cycles from one chain advance to the next.
  task automatic tick_gap(output int n);
    int i;
    n = 0;
    for (i = 0; i < 400 && PHC_TICK !== 1'b1; i++) begin
      @(posedge SYS_CLK);
      #1;
    end
    do begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end while (PHC_TICK !== 1'b1 && n < 400);
    if (n >= 400) hang("tick");
  endtask : tick_gap

  task automatic collect(input int k);
    int i;
    got_q.delete();
    for (i = 0; i < 100 * k && got_q.size() < k; i++) begin
      @(posedge SYS_CLK);
    end
    #1;
    if (got_q.size() < k) hang("output words");
    w = got_q[k-1];
  endtask : collect

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    SYS_RST   = 1'b1;
    ADDR      = 16'h0000;
    WDATA     = 8'h00;
    WR_STB    = 1'b0;
    RD_STB    = 1'b0;
    OUT_READY = 1'b0;
    sens_on   = 1'b0;
    repeat (20) @(posedge SYS_CLK);
    SYS_RST   <= 1'b0;
    OUT_READY <= 1'b1;
    sens_on   <= 1'b1;
    foreach (regs[i]) rd(regs[i], mfepc_pkg::MFE_RST_BYTE, "reset");
    chk("conv off", 0, {CONV_ON_V, CONV_ON_B, CONV_ON_A});
    wr(mfepc_pkg::MFE_ADDR_CONV, 8'h05);
    chk("conv 101", 5, {CONV_ON_V, CONV_ON_B, CONV_ON_A});
    wr(mfepc_pkg::MFE_ADDR_CONV, 8'h02);
    chk("conv 010", 2, {CONV_ON_V, CONV_ON_B, CONV_ON_A});
    rd(mfepc_pkg::MFE_ADDR_CONV, 8'h02, "conv readback");
    for (c = 0; c < 8; c++) begin
      wr(mfepc_pkg::MFE_ADDR_GAIN, {2'b00, c[2:0], c[2:0]});
      chk("gain b", 32'(gb[c]), 32'(GAIN_B));
      chk("gain a", 32'(ga[c]), 32'(GAIN_A));
    end
    wr(mfepc_pkg::MFE_ADDR_GAIN, 8'h40);
    chk("volt x2", 1, 32'(VOLT_X2));
    wr(mfepc_pkg::MFE_ADDR_GAIN, 8'h00);
    chk("volt x1", 0, 32'(VOLT_X2));
    wr(16'h2859, 8'hff);
    rd(16'h2859, 8'h00, "unmapped");
    // Each rate is timed on the second gap, after the count settles.
    for (c = 0; c < 4; c++) begin
      wr(mfepc_pkg::MFE_ADDR_CLOCK, {4'h0, c[1:0], 2'b00});
      chk("rate mult", 32'(rm[c]), 32'(RATE_MULT));
      tick_gap(g);
      tick_gap(g);
      chk("tick gap", tg[c], g);
    end
    wr(mfepc_pkg::MFE_ADDR_CLOCK, 8'h08);
    // I1 +69 with the unused bit set; I2 -3; compensation still off.
    wr(mfepc_pkg::MFE_ADDR_DLY1, 8'h45);
    wr(mfepc_pkg::MFE_ADDR_DLY2, 8'h83);
    wr(mfepc_pkg::MFE_ADDR_DLYEXT, 8'h01);
    rd(mfepc_pkg::MFE_ADDR_DLY1, 8'h45, "delay readback");
    collect(3);
    chk("off i1", 0, 32'(16'(w.i1[15:0] - w.volt[15:0])));
    chk("off i2", 0, 32'(16'(w.i2[15:0] - w.volt[15:0])));
    chk("no swap", 32'h312, {w.volt[19:16], w.i1[19:16], w.i2[19:16]});
    chk("sign copy", 3, 32'(w.volt[21:20]));
    // Voltage waits 3 steps, I1 waits 69, I2 is not held back.
    wr(mfepc_pkg::MFE_ADDR_PATH, 8'h60);
    collect(100);
    chk("swap", 32'h321, {w.volt[19:16], w.i1[19:16], w.i2[19:16]});
    chk("i1 delay", 32'hffbe, 32'(16'(w.i1[15:0] - w.volt[15:0])));
    chk("i2 delay", 3, 32'(16'(w.i2[15:0] - w.volt[15:0])));
    wr(mfepc_pkg::MFE_ADDR_PATH, 8'h00);
    collect(5);
    chk("off again", 0, 32'(16'(w.i1[15:0] - w.volt[15:0])));
    sens_on <= 1'b0;
    collect(5);
    chk("idle zero", 0, 32'(w.volt | w.i1 | w.i2));
    sens_on <= 1'b1;
    // Stall the sink until the buffer refuses, then drain it.
    OUT_READY <= 1'b0;
    repeat (200) @(posedge SYS_CLK);
    #1;
    chk("held valid", 1, 32'(OUT_VALID));
    tk = 0;
    repeat (60) begin
      @(posedge SYS_CLK);
      #1;
      tk += int'(PHC_TICK);
    end
    chk("frozen chain", 0, tk);
    @(posedge SYS_CLK);
    OUT_READY <= 1'b1;
    collect(8);
    for (c = 1; c < 8; c++) begin
      chk("no loss", 1, 32'(16'(got_q[c].volt[15:0] - got_q[c-1].volt[15:0])));
    end
    conclude();
  end
endmodule : mfepc_top_tb
